/* File: design/ssdp_top.sv */
// What this block does
// - A finished byte sets the done flag, which may interrupt and is cleared by a status read then a data access.
// - While the done flag is set, data writes are ignored until the status register has been read.
// - A data write during a running transfer sets the write collision flag.
// - A byte finishing while done is still set raises overrun, which may interrupt and clears on a status read.
// - Select going low in master operation sets mode fault, cleared by a status read then a control write.
// - Output disable releases the data output, which otherwise drives only with the peripheral enabled.
// - Soft select management ignores the select pin and uses the soft select level.
// - Under soft management a level of 0 selects the device and 1 deselects it.
// - In master operation a data write that is neither blocked by done nor colliding with a busy shifter starts a one byte full duplex transfer.
// - The received byte is copied to a buffer as done sets, and data reads return that buffer.
// - A written byte goes straight into the transmit shifter.
// - A mode fault clears peripheral enable and master select in hardware.
// - The interrupt needs irq enable and a raised and enabled done, overrun, fault or collision event.
`timescale 1ns/1ps
`default_nettype none
`include "ssdp_defs.svh"
module ssdp_top
    import ssdp_pkg::*;
#(
    parameter int SCK_HALF = `SSDP_SCK_HALF
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n,
    input wire logic ss_n_i,
    output logic irq
);

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [5:0] idx);
        return (a[7:2] == idx) && (a[1:0] == 2'b00);
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [3:0] sync1_ff, sync2_ff;
    logic [3:0] pin_raw;
    assign pin_raw = {ss_n_i, miso_i, mosi_i, sck_i};

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_ff <= `SSDP_SYNC_RST;
            sync2_ff <= `SSDP_SYNC_RST;
        end
        else
        begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end

    wire logic sck_s = sync2_ff[0];
    wire logic mosi_s = sync2_ff[1];
    wire logic miso_s = sync2_ff[2];
    wire logic ss_pin_s = sync2_ff[3];

    // ==========================================================
    // register state
    ssdp_ctrl_t ctrl_ff, nxt_ctrl;
    ssdp_csr_t csr_ff, nxt_csr;
    logic [3:0] evt_sts_ff, evt_en_ff, nxt_evt_sts;
    logic seq_arm_ff, fault_arm_ff;
    logic [7:0] rx_buf_ff;
    logic pready_ff, pslverr_ff, irq_ff;
    logic [31:0] prdata_ff;
    logic sck_oe_n_ff, mosi_oe_n_ff, miso_oe_n_ff;
    logic sck_o_ff, tx_o_ff;

    // ==========================================================
    // bus decode
    wire logic setup = psel & ~penable;
    wire logic acc = psel & penable & pready_ff;
    wire logic wr = acc & pwrite;
    wire logic rd = acc & ~pwrite;
    wire logic hit_data = addr_hit(paddr, `SSDP_IDX_DATA);
    wire logic hit_ctrl = addr_hit(paddr, `SSDP_IDX_CTRL);
    wire logic hit_csr = addr_hit(paddr, `SSDP_IDX_CSR);
    wire logic hit_sts = addr_hit(paddr, `SSDP_IDX_EVT_STS);
    wire logic hit_clr = addr_hit(paddr, `SSDP_IDX_EVT_CLR);
    wire logic hit_en = addr_hit(paddr, `SSDP_IDX_EVT_EN);
    wire logic mapped = hit_data | hit_ctrl | hit_csr | hit_sts | hit_clr
                        | hit_en;

    wire logic [7:0] csr_rd = {csr_ff[7:4], 1'b0, csr_ff[2:0]};
    wire logic [7:0] rd_mux =
        hit_data ? rx_buf_ff :
        hit_ctrl ? ctrl_ff :
        hit_csr ? csr_rd :
        hit_sts ? {4'h0, evt_sts_ff} :
        hit_en ? {4'h0, evt_en_ff} : 8'h00;

    // ==========================================================
    // internal select and shifter
    wire logic ss_int = csr_ff.soft_select_manage ?
                        csr_ff.soft_select_level : ss_pin_s;
    wire logic pe = ctrl_ff.peripheral_enable;
    wire logic ms = ctrl_ff.master_select;
    wire logic selected = ~ss_int;
    wire logic sh_busy, sh_done, sh_tx, sh_sck;
    wire logic [7:0] sh_rx;

    wire logic data_wr = wr & hit_data;
    wire logic data_rd = rd & hit_data;
    wire logic ctrl_wr = wr & hit_ctrl;
    wire logic csr_wr = wr & hit_csr;
    wire logic csr_read = rd & hit_csr;
    wire logic wr_blocked = csr_ff.transfer_done_flag & ~seq_arm_ff;
    wire logic coll_set = data_wr & sh_busy;
    wire logic sh_load = data_wr & ~wr_blocked & ~sh_busy;
    wire logic seq_clear = (data_wr | data_rd) & seq_arm_ff;
    wire logic ovr_set = sh_done & csr_ff.transfer_done_flag;
    wire logic ovr_clear = csr_read & prdata_ff[`SSDP_CSR_OVERRUN_BIT];
    wire logic fault_set = pe & ms & ~ss_int;
    wire logic fault_clear = ctrl_wr & fault_arm_ff;
    wire logic rx_s = ms ? miso_s : mosi_s;

    ssdp_shifter #(
        .HALF(SCK_HALF)
    ) u_shifter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .enable(pe),
        .master(ms),
        .selected(selected),
        .sck_s(sck_s),
        .rx_s(rx_s),
        .load(sh_load),
        .load_byte(pwdata[7:0]),
        .busy(sh_busy),
        .done(sh_done),
        .tx_bit(sh_tx),
        .sck_out(sh_sck),
        .rx_byte(sh_rx)
    );

    // ==========================================================
    // next values of control, status and events
    always_comb
    begin
        nxt_ctrl = ctrl_wr ? ssdp_ctrl_t'(pwdata[7:0]) : ctrl_ff;
        if (fault_set)
        begin
            nxt_ctrl.peripheral_enable = 1'b0;
            nxt_ctrl.master_select = 1'b0;
        end
        nxt_csr = csr_ff;
        if (csr_wr)
        begin
            nxt_csr.output_disable = pwdata[2];
            nxt_csr.soft_select_manage = pwdata[1];
            nxt_csr.soft_select_level = pwdata[0];
        end
        nxt_csr.reserved = 1'b0;
        nxt_csr.transfer_done_flag = sh_done
            | (csr_ff.transfer_done_flag & ~seq_clear);
        nxt_csr.write_collision_flag = coll_set
            | (csr_ff.write_collision_flag & ~seq_clear);
        nxt_csr.overrun_flag = ovr_set
            | (csr_ff.overrun_flag & ~ovr_clear);
        nxt_csr.mode_fault_flag = fault_set
            | (csr_ff.mode_fault_flag & ~fault_clear);
        nxt_evt_sts = evt_sts_ff & ~((wr & hit_clr) ? pwdata[3:0] : 4'h0);
        nxt_evt_sts[`SSDP_EVT_DONE] = nxt_evt_sts[`SSDP_EVT_DONE] | sh_done;
        nxt_evt_sts[`SSDP_EVT_OVERRUN] = nxt_evt_sts[`SSDP_EVT_OVERRUN]
            | ovr_set;
        nxt_evt_sts[`SSDP_EVT_FAULT] = nxt_evt_sts[`SSDP_EVT_FAULT]
            | fault_set;
        nxt_evt_sts[`SSDP_EVT_COLL] = nxt_evt_sts[`SSDP_EVT_COLL] | coll_set;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_ff <= `SSDP_CTRL_RST;
            csr_ff <= `SSDP_CSR_RST;
            evt_sts_ff <= 4'h0;
            evt_en_ff <= `SSDP_EVT_EN_RST;
            seq_arm_ff <= 1'b0;
            fault_arm_ff <= 1'b0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            csr_ff <= nxt_csr;
            evt_sts_ff <= nxt_evt_sts;
            if (wr & hit_en)
                evt_en_ff <= pwdata[3:0];
            if (csr_read & (csr_ff.transfer_done_flag
                            | csr_ff.write_collision_flag))
                seq_arm_ff <= 1'b1;
            else if (data_wr | data_rd)
                seq_arm_ff <= 1'b0;
            if (csr_read & csr_ff.mode_fault_flag)
                fault_arm_ff <= 1'b1;
            else if (ctrl_wr)
                fault_arm_ff <= 1'b0;
        end
    end

    // receive buffer keeps the old byte on overrun
    always_ff @(posedge clk_sys)
    begin
        if (sh_done & ~csr_ff.transfer_done_flag)
            rx_buf_ff <= sh_rx;
    end

    // ==========================================================
    // bus answer, pins and interrupt
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            sck_oe_n_ff <= 1'b1;
            mosi_oe_n_ff <= 1'b1;
            miso_oe_n_ff <= 1'b1;
            sck_o_ff <= 1'b0;
            tx_o_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup)
                prdata_ff <= {24'h00_0000, rd_mux};
            irq_ff <= ctrl_ff.irq_enable
                      & |(evt_sts_ff & evt_en_ff);
            sck_oe_n_ff <= ~(pe & ms);
            mosi_oe_n_ff <= ~(pe & ~csr_ff.output_disable & ms);
            miso_oe_n_ff <= ~(pe & ~csr_ff.output_disable & ~ms
                              & selected);
            sck_o_ff <= sh_sck;
            tx_o_ff <= sh_tx;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign sck_oe_n = sck_oe_n_ff;
    assign mosi_oe_n = mosi_oe_n_ff;
    assign miso_oe_n = miso_oe_n_ff;
    assign sck_o = sck_o_ff;
    assign mosi_o = tx_o_ff;
    assign miso_o = tx_o_ff;

    // ==========================================================
    // checks
    property p_done_set;
        @(posedge clk_sys) disable iff (!resetn)
        sh_done |=> csr_ff.transfer_done_flag;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set after byte");

    property p_blocked;
        @(posedge clk_sys) disable iff (!resetn)
        (data_wr & csr_ff.transfer_done_flag & ~seq_arm_ff) |-> ~sh_load;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("data write taken while done flag set");

    property p_coll;
        @(posedge clk_sys) disable iff (!resetn)
        (data_wr & sh_busy) |=> csr_ff.write_collision_flag;
    endproperty
    a_coll: assert property (p_coll)
        else $error("write collision not flagged");

    property p_overrun;
        @(posedge clk_sys) disable iff (!resetn)
        (sh_done & csr_ff.transfer_done_flag)
            |=> csr_ff.overrun_flag && $stable(rx_buf_ff);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged or buffer overwritten");

    property p_fault;
        @(posedge clk_sys) disable iff (!resetn)
        (pe & ms & ~ss_int) |=> csr_ff.mode_fault_flag
            && !ctrl_ff.peripheral_enable && !ctrl_ff.master_select;
    endproperty
    a_fault: assert property (p_fault)
        else $error("mode fault not handled");

    property p_out_gate;
        @(posedge clk_sys) disable iff (!resetn)
        (csr_ff.output_disable | ~pe) |=> mosi_oe_n && miso_oe_n;
    endproperty
    a_out_gate: assert property (p_out_gate)
        else $error("data output driven while disabled");

    property p_soft_sel;
        @(posedge clk_sys) disable iff (!resetn)
        (csr_ff.soft_select_manage & ~csr_ff.soft_select_level & pe & ms)
            |=> csr_ff.mode_fault_flag;
    endproperty
    a_soft_sel: assert property (p_soft_sel)
        else $error("soft select level ignored");

    property p_start;
        @(posedge clk_sys) disable iff (!resetn)
        (sh_load & pe & ms) |=> sh_busy [*3];
    endproperty
    a_start: assert property (p_start)
        else $error("master write did not start a transfer");

    property p_irq;
        @(posedge clk_sys) disable iff (!resetn)
        irq |-> $past(ctrl_ff.irq_enable) && ($past(evt_sts_ff) != 4'h0);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without enabled event");

endmodule // ssdp_top
`default_nettype wire

/* File: design/ssdp_defs.svh */
`ifndef SSDP_DEFS_SVH
`define SSDP_DEFS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define SSDP_IDX_DATA 6'h21
`define SSDP_IDX_CTRL 6'h22
`define SSDP_IDX_CSR 6'h23
`define SSDP_IDX_EVT_STS 6'h24
`define SSDP_IDX_EVT_CLR 6'h25
`define SSDP_IDX_EVT_EN 6'h26

// ==========================================================
// reset values
`define SSDP_CTRL_RST 8'h00
`define SSDP_CSR_RST 8'h00
`define SSDP_EVT_EN_RST 4'hF
`define SSDP_SYNC_RST 4'h8

// ==========================================================
// event bit positions
`define SSDP_EVT_DONE 0
`define SSDP_EVT_OVERRUN 1
`define SSDP_EVT_FAULT 2
`define SSDP_EVT_COLL 3

// ==========================================================
// control/status field positions
`define SSDP_CSR_OVERRUN_BIT 5

// ==========================================================
// timing
`define SSDP_SCK_HALF 4
`define SSDP_BITS 4'h8

`endif

/* File: design/ssdp_pkg.sv */
`default_nettype none
package ssdp_pkg;

    // serial_control fields
    typedef struct packed {
        logic irq_enable;
        logic peripheral_enable;
        logic div_enable;
        logic master_select;
        logic cpol;
        logic cpha;
        logic [1:0] rate;
    } ssdp_ctrl_t;

    // serial_control_status fields
    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic overrun_flag;
        logic mode_fault_flag;
        logic reserved;
        logic output_disable;
        logic soft_select_manage;
        logic soft_select_level;
    } ssdp_csr_t;

    typedef enum logic [0:0] {
        SSDP_SH_IDLE = 1'b0,
        SSDP_SH_RUN = 1'b1
    } ssdp_sh_state_t;

endpackage
`default_nettype wire

/* File: design/ssdp_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssdp_defs.svh"
module ssdp_shifter
    import ssdp_pkg::*;
#(
    parameter int HALF = `SSDP_SCK_HALF
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic enable,
    input wire logic master,
    input wire logic selected,
    input wire logic sck_s,
    input wire logic rx_s,
    input wire logic load,
    input wire logic [7:0] load_byte,
    output logic busy,
    output logic done,
    output logic tx_bit,
    output logic sck_out,
    output logic [7:0] rx_byte
);

    ssdp_sh_state_t state_ff, nxt_state;
    logic [7:0] sh_ff;
    logic [3:0] cnt_ff;
    logic [7:0] div_ff;
    logic sck_ff, sck_d_ff, rbit_ff, done_ff;

    // ==========================================================
    // edge decode, master divider or sampled slave clock
    wire logic running = (state_ff == SSDP_SH_RUN);
    wire logic div_end = (div_ff == 8'(HALF - 1));
    wire logic m_tick = running & div_end;
    wire logic s_sel = ~master & selected & enable;
    wire logic rise = (m_tick & ~sck_ff) | (s_sel & sck_s & ~sck_d_ff);
    wire logic fall = (m_tick & sck_ff) | (s_sel & ~sck_s & sck_d_ff);
    wire logic last = fall & (cnt_ff == `SSDP_BITS - 4'h1);
    wire logic cnt_clr = load | ~enable | (~master & ~selected);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            SSDP_SH_IDLE:
                if (load & master & enable)
                    nxt_state = SSDP_SH_RUN;
            SSDP_SH_RUN:
                if (~enable | ~master | last)
                    nxt_state = SSDP_SH_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= SSDP_SH_IDLE;
            sh_ff <= 8'h00;
            cnt_ff <= 4'h0;
            div_ff <= 8'h00;
            sck_ff <= 1'b0;
            sck_d_ff <= 1'b0;
            rbit_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            sck_d_ff <= sck_s;
            done_ff <= last & enable;
            div_ff <= (running & ~div_end) ? div_ff + 8'h01 : 8'h00;
            sck_ff <= (running & enable & master) ? sck_ff ^ m_tick : 1'b0;
            if (rise)
                rbit_ff <= rx_s;
            // byte goes straight into the shifter
            if (load)
                sh_ff <= load_byte;
            else if (fall)
                sh_ff <= {sh_ff[6:0], rbit_ff};
            if (cnt_clr)
                cnt_ff <= 4'h0;
            else if (fall)
                cnt_ff <= last ? 4'h0 : cnt_ff + 4'h1;
        end
    end

    assign busy = running | (cnt_ff != 4'h0);
    assign done = done_ff;
    assign tx_bit = sh_ff[7];
    assign sck_out = sck_ff;
    assign rx_byte = sh_ff;

endmodule // ssdp_shifter
`default_nettype wire

/* File: bench/ssdp_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far-side spi device: slave that echoes tx_byte, or master
module ssdp_peer
(
    input wire logic role_master,
    input wire logic [7:0] tx_byte,
    input wire logic sck_w,
    input wire logic mosi_w,
    output logic sck,
    output logic sck_drv,
    output logic mosi,
    output logic mosi_drv,
    output logic miso,
    output logic miso_drv,
    output logic [7:0] rx_byte,
    output var int rx_count
);
    logic [7:0] sh;
    logic [2:0] nb;
    logic [2:0] nbf;

    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        mosi_drv = 1'b0;
        rx_count = 0;
        nb = 3'h0;
        nbf = 3'h0;
    end

    assign sck_drv = role_master;
    assign miso_drv = !role_master;
    // msb first, next bit presented after each falling edge
    assign miso = tx_byte[3'h7 - nbf];

    always @(posedge sck_w)
    begin
        if (!role_master)
        begin
            sh = {sh[6:0], mosi_w};
            nb = nb + 3'h1;
            if (nb == 3'h0)
            begin
                rx_byte = sh;
                rx_count++;
            end
        end
    end

    always @(negedge sck_w)
    begin
        if (!role_master)
            nbf = nbf + 3'h1;
    end

    // realign bit counters after the line carried noise
    task sync;
        nb = 3'h0;
        nbf = 3'h0;
    endtask

    // clock idles low outside frames, 200 ns period
    task send(input logic [7:0] b);
        // keep link edges off the system clock edge
        #5;
        mosi_drv = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            mosi = b[i];
            #100 sck = 1'b1;
            #100 sck = 1'b0;
        end
        mosi_drv = 1'b0;
    endtask
endmodule // ssdp_peer
`default_nettype wire

/* File: bench/tb_spi_status_and_data_path.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssdp_defs.svh"
module tb_spi_status_and_data_path;
    typedef struct {
        logic [7:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } ssdp_row_t;
    localparam logic [7:0] A_DAT = {`SSDP_IDX_DATA, 2'b00};
    localparam logic [7:0] A_CTL = {`SSDP_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_CSR = {`SSDP_IDX_CSR, 2'b00};
    localparam logic [7:0] A_STS = {`SSDP_IDX_EVT_STS, 2'b00};
    localparam logic [7:0] A_CLR = {`SSDP_IDX_EVT_CLR, 2'b00};
    localparam logic [7:0] A_EN = {`SSDP_IDX_EVT_EN, 2'b00};
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic junk = 1'b0;
    logic [7:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] pwdata, prdata, rd;
    logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic irq, ss_n_i, p_role, p_sck, p_sck_drv, p_mosi, p_mosi_drv;
    logic p_miso, p_miso_drv;
    logic [7:0] p_tx, p_rx;
    int p_cnt, fails, checks_done, c;
    ssdp_row_t rows [9];
    // undriven lines show a changing pattern
    wire logic sck_w = !sck_oe_n ? sck_o : p_sck_drv ? p_sck : junk;
    wire logic mosi_w = !mosi_oe_n ? mosi_o : p_mosi_drv ? p_mosi : junk;
    wire logic miso_w = !miso_oe_n ? miso_o : p_miso_drv ? p_miso : junk;

    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) junk <= ~junk;

    ssdp_top #(.SCK_HALF(4)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n), .ss_n_i(ss_n_i), .irq(irq));

    ssdp_peer u_peer (.role_master(p_role), .tx_byte(p_tx),
        .sck_w(sck_w), .mosi_w(mosi_w), .sck(p_sck), .sck_drv(p_sck_drv),
        .mosi(p_mosi), .mosi_drv(p_mosi_drv), .miso(p_miso),
        .miso_drv(p_miso_drv), .rx_byte(p_rx), .rx_count(p_cnt));

    // ==========================================================
    // helpers
    task summarize;
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk_val(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task chk_pin(input logic g, input logic x);
        checks_done++;
        if (g !== x)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            fails++;
            summarize();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        chk_val(rd, x);
    endtask

    task wait_evt(input int b);
        int n;
        for (n = 0; n < 400; n++)
        begin
            apb(A_STS, 1'b0, 32'h0);
            if (rd[b] === 1'b1)
                break;
        end
        if (n == 400)
        begin
            fails++;
            summarize();
        end
    endtask

    // ==========================================================
    // sequence
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ss_n_i = 1'b1;
        p_role = 1'b0;
        p_tx = 8'h3C;
        fails = 0;
        checks_done = 0;
        rows = '{'{A_CSR, 1'b0, 32'h0, 32'h0, 1'b0},
            '{A_CTL, 1'b0, 32'h0, 32'h0, 1'b0},
            '{A_EN, 1'b0, 32'h0, 32'hF, 1'b0},
            '{A_CTL, 1'b1, 32'hAF, 32'h0, 1'b0},
            '{A_CTL, 1'b0, 32'h0, 32'hAF, 1'b0},
            '{A_CSR, 1'b1, 32'h07, 32'h0, 1'b0},
            '{A_CSR, 1'b0, 32'h0, 32'h07, 1'b0},
            '{8'h00, 1'b0, 32'h0, 32'h0, 1'b1},
            '{8'hFC, 1'b1, 32'h3F, 32'h0, 1'b1}};
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        chk_pin(irq, 1'b0);
        chk_pin(sck_oe_n & mosi_oe_n & miso_oe_n, 1'b1);
        for (int i = 0; i < 9; i++)
        begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w)
                chk_val(rd, rows[i].x);
            chk_pin(er, rows[i].e);
        end
        $display("test registers done");
        apb(A_CLR, 1'b1, 32'hF);
        apb(A_CTL, 1'b1, 32'hD0);
        apb(A_CSR, 1'b1, 32'h03);
        repeat (2) @(posedge clk_sys);
        chk_pin(mosi_oe_n, 1'b0);
        u_peer.sync();
        apb(A_DAT, 1'b1, 32'hA5);
        apb(A_DAT, 1'b1, 32'h11);
        wait_evt(`SSDP_EVT_DONE);
        chk_val({24'h0, p_rx}, 32'hA5);
        repeat (2) @(posedge clk_sys);
        chk_pin(irq, 1'b1);
        apb(A_EN, 1'b1, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk_pin(irq, 1'b0);
        apb(A_EN, 1'b1, 32'hF);
        rd_chk(A_CSR, 32'hC3);
        rd_chk(A_DAT, 32'h3C);
        rd_chk(A_CSR, 32'h03);
        apb(A_CLR, 1'b1, 32'hF);
        repeat (2) @(posedge clk_sys);
        chk_pin(irq, 1'b0);
        apb(A_DAT, 1'b1, 32'h96);
        wait_evt(`SSDP_EVT_DONE);
        c = p_cnt;
        apb(A_DAT, 1'b1, 32'h55);
        repeat (120) @(posedge clk_sys);
        chk_val(p_cnt, c);
        rd_chk(A_CSR, 32'h83);
        apb(A_CLR, 1'b1, 32'hF);
        apb(A_DAT, 1'b1, 32'h5A);
        wait_evt(`SSDP_EVT_DONE);
        chk_val({24'h0, p_rx}, 32'h5A);
        apb(A_CSR, 1'b0, 32'h0);
        apb(A_DAT, 1'b0, 32'h0);
        rd_chk(A_CSR, 32'h03);
        $display("test master done");
        apb(A_CSR, 1'b1, 32'h0);
        apb(A_CLR, 1'b1, 32'hF);
        ss_n_i <= 1'b0;
        wait_evt(`SSDP_EVT_FAULT);
        rd_chk(A_CTL, 32'h80);
        chk_pin(sck_oe_n, 1'b1);
        rd_chk(A_CSR, 32'h10);
        chk_pin(irq, 1'b1);
        ss_n_i <= 1'b1;
        apb(A_CTL, 1'b1, 32'hD0);
        rd_chk(A_CSR, 32'h00);
        apb(A_CLR, 1'b1, 32'hF);
        apb(A_CSR, 1'b1, 32'h03);
        ss_n_i <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rd_chk(A_CSR, 32'h03);
        rd_chk(A_CTL, 32'hD0);
        apb(A_CSR, 1'b1, 32'h02);
        rd_chk(A_CSR, 32'h12);
        apb(A_CSR, 1'b1, 32'h03);
        $display("test fault done");
        apb(A_CTL, 1'b1, 32'hC0);
        p_role <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk_pin(miso_oe_n, 1'b1);
        apb(A_CSR, 1'b1, 32'h02);
        repeat (2) @(posedge clk_sys);
        chk_pin(miso_oe_n, 1'b0);
        apb(A_CSR, 1'b1, 32'h06);
        repeat (2) @(posedge clk_sys);
        chk_pin(miso_oe_n, 1'b1);
        apb(A_CSR, 1'b1, 32'h02);
        apb(A_DAT, 1'b1, 32'h80);
        repeat (2) @(posedge clk_sys);
        chk_pin(miso_o, 1'b1);
        apb(A_CLR, 1'b1, 32'hF);
        u_peer.send(8'h6B);
        u_peer.send(8'hE1);
        wait_evt(`SSDP_EVT_OVERRUN);
        rd_chk(A_CSR, 32'hA2);
        rd_chk(A_CSR, 32'h82);
        rd_chk(A_DAT, 32'h6B);
        $display("test slave done");
        summarize();
    end
endmodule // tb_spi_status_and_data_path
`default_nettype wire
